// [core/dml_consts.svh]
/*
 Constants of the diagnostic message log: storage depth, subindex map,
 text identifier digits, severity flags and timing.
 Assumes inclusion by bare name from core/ sources.
*/
`ifndef DML_CONSTS_SVH
`define DML_CONSTS_SVH

`define DML_DEPTH         250
`define DML_IDX_W         8
`define DML_FIRST_SUB     8'h06
`define DML_NO_ENTRY      8'h00
`define DML_CODE_PREFIX   16'he000
`define DML_FLAGS_W       16
`define DML_SEV_INFO      2'h0
`define DML_SEV_WARN      2'h1
`define DML_SEV_ERROR     2'h2
`define DML_TYPE_SYSINFO  4'h0
`define DML_TYPE_INFO     4'h1
`define DML_TYPE_RSVD     4'h2
`define DML_TYPE_WARN     4'h4
`define DML_TYPE_ERROR    4'h8
`define DML_PLACE_SYSTEM  4'h0
`define DML_PLACE_GENERAL 4'h1
`define DML_PLACE_RSVD    4'h7
`define DML_ESM_INIT      4'h1
`define DML_ESM_PRE_OPERATIONAL_STATE     4'h2
`define DML_ESM_SAFE_OPERATIONAL_STATE    4'h4
`define DML_ESM_OP        4'h8
`define DML_TID_MODE_DONE 16'h1100
`define DML_CLK_PERIOD_NS 40

`endif

// [core/dml_pkg.sv]
/*
 Types of the diagnostic message log.
 Assumes dml_consts.svh is on the include path.
*/
`default_nettype none
`include "dml_consts.svh"

package dml_pkg;

   typedef struct packed {
      logic [31:0] code;
      logic [15:0] flags;
      logic [15:0] text_identifier;
      logic [63:0] stamp;
      logic [31:0] param;
   } dml_entry_t;

   typedef enum logic [1:0] {
      DML_SRC_ESM  = 2'h0,
      DML_SRC_MODE = 2'h1,
      DML_SRC_EVT  = 2'h2
   } dml_src_t;

endpackage

`default_nettype wire

// [core/dml_hist_if.sv]
/*
 Carrier between the log controller and its entry storage.
 Assumes one clock; storage read paths are combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dml_consts.svh"

interface dml_hist_if;
   logic                   wr_en;
   logic [`DML_IDX_W-1:0]  wr_idx;
   dml_pkg::dml_entry_t    wr_entry;
   logic [`DML_IDX_W-1:0]  rd_idx;
   dml_pkg::dml_entry_t    rd_entry;
   logic                   rd_confirmed;
   logic [`DML_IDX_W-1:0]  chk_idx;
   logic                   chk_confirmed;
   logic                   ack_en;

   modport ctl (output wr_en, wr_idx, wr_entry, rd_idx, chk_idx, ack_en,
                input rd_entry, rd_confirmed, chk_confirmed);
   modport mem (input wr_en, wr_idx, wr_entry, rd_idx, chk_idx, ack_en,
                output rd_entry, rd_confirmed, chk_confirmed);
endinterface

`default_nettype wire

// [core/dml_history_mem.sv]
/*
 Entry storage of the diagnostic log: flip-flop array with a confirmed
 bit per slot. Assumes the controller keeps indices below DEPTH.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dml_consts.svh"

module dml_history_mem #(
   parameter int DEPTH = `DML_DEPTH
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   dml_hist_if.mem  hist
);
   dml_pkg::dml_entry_t store_q [DEPTH];
   logic [DEPTH-1:0]    conf_q;
   wire                 rd_in = hist.rd_idx < DEPTH;
   wire                 chk_in = hist.chk_idx < DEPTH;

   assign hist.rd_entry      = rd_in ? store_q[hist.rd_idx] : '0;
   assign hist.rd_confirmed  = rd_in ? conf_q[hist.rd_idx] : 1'b0;
   assign hist.chk_confirmed = chk_in ? conf_q[hist.chk_idx] : 1'b0;

   // Payload is not reset; only written slots are ever read back
   always_ff @(posedge ref_clk) begin
      if (clk_en && hist.wr_en) begin
         store_q[hist.wr_idx] <= hist.wr_entry;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         conf_q <= '0;
      end else if (clk_en) begin
         if (hist.wr_en) begin
            conf_q[hist.wr_idx] <= 1'b0;                // see R6
         end
         if (hist.ack_en) begin
            conf_q[hist.chk_idx] <= 1'b1;               // see R6
         end
      end
   end
endmodule

`default_nettype wire

// [core/dml_text_identifier_enc.sv]
/*
 Builds text identifier, severity flags and diagnostic code of an entry
 from its type digit, place digit and error number. Purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dml_consts.svh"

module dml_text_identifier_enc (
   input  wire logic [3:0]  type_digit,
   input  wire logic [3:0]  place_digit,
   input  wire logic [7:0]  number,
   output logic [15:0]      text_identifier,
   output logic [15:0]      flags,
   output logic [31:0]      code
);
   function automatic logic [1:0] sev_of(input logic [3:0] t);
      sev_of = (t == `DML_TYPE_ERROR) ? `DML_SEV_ERROR :
               (t == `DML_TYPE_WARN)  ? `DML_SEV_WARN  : `DML_SEV_INFO;
   endfunction

   assign text_identifier = {type_digit, place_digit, number};               // see R8 see R9
   assign flags   = {{(`DML_FLAGS_W-2){1'b0}}, sev_of(type_digit)};  // see R3
   assign code    = {`DML_CODE_PREFIX, text_identifier};                     // see R3
endmodule

`default_nettype wire

// [core/dml_log_top.sv]
/*
 Diagnostic message log: records coded entries for events, bus state
 changes and mode detection, keeps the newest subindex, a fresh-entries
 flag and per-entry confirmation, and answers master reads.
 Assumes all inputs come from logic on ref_clk.
*/
// Operation
// R1: Log one coded entry per detected event
// R2: History holds at most 250 entries
// R3: Entry: code, flags, text identifier, timestamp, parameters
// R4: Timestamp is local time or 64-bit clock
// R5: Indicator shows stored, uncollected new entries
// R6: Master acknowledges newest unconfirmed; becomes confirmed
// R7: Newest entry subindex is readable
// R8: Top identifier digit encodes message type
// R9: Second digit place, low byte error number
// R10: Timestamp taken from system time at event
// R11: Bus state change logs info with states
// R12: Mode detection done logs identifier 0x1100
// R13: Reference clock time readable by master
// R14: Full history overwrites oldest, wraps subindex
// R15: Indicator clears on collection, sets on store
`timescale 1ns/1ps
`default_nettype none
`include "dml_consts.svh"

module dml_log_top #(
   parameter int DEPTH = `DML_DEPTH
) (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   input  wire logic        evt_valid,
   input  wire logic [3:0]  evt_type,
   input  wire logic [3:0]  evt_place,
   input  wire logic [7:0]  evt_number,
   input  wire logic [31:0] evt_param,
   input  wire logic        esm_change,
   input  wire logic [3:0]  esm_from,
   input  wire logic [3:0]  esm_to,
   input  wire logic        mode_done,
   input  wire logic [7:0]  mode_value,
   input  wire logic [15:0] mode_param,
   input  wire logic        dc_available,
   input  wire logic        dc_is_reference,
   input  wire logic [63:0] dc_sys_time,
   input  wire logic        time_latch,
   input  wire logic        rd_req,
   input  wire logic [7:0]  rd_subindex,
   input  wire logic        ack_req,
   input  wire logic [7:0]  ack_subindex,
   output logic             rd_valid_q,
   output logic             rd_hit_q,
   output logic [31:0]      rd_code_q,
   output logic [15:0]      rd_flags_q,
   output logic [15:0]      rd_text_identifier_q,
   output logic [63:0]      rd_stamp_q,
   output logic [31:0]      rd_param_q,
   output logic             rd_confirmed_q,
   output logic             ack_done_q,
   output logic             ack_refused_q,
   output logic [7:0]       newest_sub_q,
   output logic             fresh_entries_indicator_q,
   output logic [7:0]       entry_count_q,
   output logic [63:0]      dc_receive_time_q
);
   localparam logic [7:0]  LAST_IDX  = 8'(DEPTH - 1);
   localparam logic [7:0]  DEPTH_W   = 8'(DEPTH);
   localparam logic [63:0] TIME_STEP = 64'(`DML_CLK_PERIOD_NS);

   function automatic logic [7:0] sub_to_idx(input logic [7:0] s);
      sub_to_idx = s - `DML_FIRST_SUB;
   endfunction

   function automatic logic [7:0] idx_to_sub(input logic [7:0] i);
      idx_to_sub = i + `DML_FIRST_SUB;
   endfunction

   function automatic logic in_history(input logic [7:0] s, input logic [7:0] cnt);
      in_history = (s >= `DML_FIRST_SUB) && (sub_to_idx(s) < cnt);
   endfunction

   // Count stops at the depth; wrapped writes replace, not add
   function automatic logic [7:0] sat_inc(input logic [7:0] c);
      sat_inc = (c == DEPTH_W) ? c : c + 8'h01;
   endfunction

   function automatic logic [63:0] stamp_now(input logic dc, input logic [63:0] dct,
                                             input logic [63:0] loc);
      stamp_now = dc ? dct : loc;
   endfunction

   dml_hist_if hist ();

   logic [63:0] local_time_q;
   logic        esm_pend_q;
   logic [7:0]  esm_states_q;
   logic [63:0] esm_stamp_q;
   logic        mode_pend_q;
   logic [31:0] mode_par_q;
   logic [63:0] mode_stamp_q;
   logic        evt_pend_q;
   logic [15:0] evt_id_q;
   logic [31:0] evt_par_q;
   logic [63:0] evt_stamp_q;
   logic [7:0]  newest_idx_q;
   logic [7:0]  count_q;

   // Time taken when the event arrives, not when it is written
   wire [63:0] stamp_d = stamp_now(dc_available, dc_sys_time, local_time_q); // see R4 see R10

   // Fixed priority keeps storage to one write port
   wire serve_esm  = esm_pend_q;
   wire serve_mode = mode_pend_q && !esm_pend_q;
   wire serve_evt  = evt_pend_q && !esm_pend_q && !mode_pend_q;
   wire do_write   = serve_esm || serve_mode || serve_evt;

   dml_pkg::dml_src_t src;
   assign src = serve_esm  ? dml_pkg::DML_SRC_ESM :
                serve_mode ? dml_pkg::DML_SRC_MODE : dml_pkg::DML_SRC_EVT;

   // Fixed mode identifier is split into its digits for the encoder
   wire [15:0] mode_tid  = `DML_TID_MODE_DONE;
   wire [3:0] sel_type   = (src == dml_pkg::DML_SRC_EVT)  ? evt_id_q[15:12] :
                           (src == dml_pkg::DML_SRC_MODE) ? mode_tid[15:12] : `DML_TYPE_INFO;
   wire [3:0] sel_place  = (src == dml_pkg::DML_SRC_ESM)  ? `DML_PLACE_SYSTEM :
                           (src == dml_pkg::DML_SRC_MODE) ? mode_tid[11:8] :
                           evt_id_q[11:8];
   wire [7:0] sel_number = (src == dml_pkg::DML_SRC_ESM)  ? esm_states_q :      // see R11
                           (src == dml_pkg::DML_SRC_MODE) ? mode_tid[7:0] :      // see R12
                           evt_id_q[7:0];
   wire [31:0] sel_param = (src == dml_pkg::DML_SRC_ESM)  ? 32'h0000_0000 :
                           (src == dml_pkg::DML_SRC_MODE) ? mode_par_q : evt_par_q;
   wire [63:0] sel_stamp = (src == dml_pkg::DML_SRC_ESM)  ? esm_stamp_q :
                           (src == dml_pkg::DML_SRC_MODE) ? mode_stamp_q : evt_stamp_q;

   logic [15:0] enc_text_identifier;
   logic [15:0] enc_flags;
   logic [31:0] enc_code;

   dml_text_identifier_enc u_enc (
      .type_digit  (sel_type),
      .place_digit (sel_place),
      .number      (sel_number),
      .text_identifier     (enc_text_identifier),
      .flags       (enc_flags),
      .code        (enc_code)
   );

   // Oldest slot is reused once the history is full
   wire [7:0] wr_idx = (count_q == 8'h00) ? 8'h00 :
                       (newest_idx_q == LAST_IDX) ? 8'h00 :             // see R14
                       newest_idx_q + 8'h01;

   assign hist.wr_en            = do_write;                             // see R1
   assign hist.wr_idx           = wr_idx;
   assign hist.wr_entry.code    = enc_code;                             // see R3
   assign hist.wr_entry.flags   = enc_flags;
   assign hist.wr_entry.text_identifier = enc_text_identifier;
   assign hist.wr_entry.stamp   = sel_stamp;
   assign hist.wr_entry.param   = sel_param;

   wire rd_in    = in_history(rd_subindex, count_q);
   wire rd_newest = rd_req && rd_in && (rd_subindex == newest_sub_q);
   assign hist.rd_idx  = sub_to_idx(rd_subindex);
   assign hist.chk_idx = newest_idx_q;

   // Only the newest entry may be confirmed, and only once
   wire ack_ok = ack_req && (count_q != 8'h00) && !do_write &&
                 (ack_subindex == newest_sub_q) && !hist.chk_confirmed;  // see R6
   assign hist.ack_en = ack_ok;

   dml_history_mem #(
      .DEPTH (DEPTH)
   ) u_mem (
      .ref_clk (ref_clk),
      .reset   (reset),
      .clk_en  (clk_en),
      .hist    (hist)
   );

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         local_time_q <= 64'h0000_0000_0000_0000;
      end else if (clk_en) begin
         local_time_q <= local_time_q + TIME_STEP;                      // see R4
      end
   end

   // Arrival sets the pending flag even in its serve cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         esm_pend_q   <= 1'b0;
         esm_states_q <= 8'h00;
         esm_stamp_q  <= 64'h0000_0000_0000_0000;
      end else if (clk_en) begin
         if (esm_change) begin
            esm_pend_q   <= 1'b1;
            esm_states_q <= {esm_from, esm_to};                         // see R11
            esm_stamp_q  <= stamp_d;                                    // see R10
         end else if (serve_esm) begin
            esm_pend_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mode_pend_q  <= 1'b0;
         mode_par_q   <= 32'h0000_0000;
         mode_stamp_q <= 64'h0000_0000_0000_0000;
      end else if (clk_en) begin
         if (mode_done) begin
            mode_pend_q  <= 1'b1;
            mode_par_q   <= {8'h00, mode_value, mode_param};            // see R12
            mode_stamp_q <= stamp_d;
         end else if (serve_mode) begin
            mode_pend_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         evt_pend_q  <= 1'b0;
         evt_id_q    <= 16'h0000;
         evt_par_q   <= 32'h0000_0000;
         evt_stamp_q <= 64'h0000_0000_0000_0000;
      end else if (clk_en) begin
         if (evt_valid) begin
            evt_pend_q  <= 1'b1;                                        // see R1
            evt_id_q    <= {evt_type, evt_place, evt_number};           // see R8 see R9
            evt_par_q   <= evt_param;
            evt_stamp_q <= stamp_d;                                     // see R10
         end else if (serve_evt) begin
            evt_pend_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         newest_idx_q  <= 8'h00;
         count_q       <= 8'h00;
         newest_sub_q  <= `DML_NO_ENTRY;
         entry_count_q <= 8'h00;
      end else if (clk_en && do_write) begin
         newest_idx_q  <= wr_idx;
         newest_sub_q  <= idx_to_sub(wr_idx);                           // see R7 see R14
         count_q       <= sat_inc(count_q);                             // see R2
         entry_count_q <= sat_inc(count_q);
      end
   end

   // A store in the same cycle as a collection keeps the flag set
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         fresh_entries_indicator_q <= 1'b0;
      end else if (clk_en) begin
         if (do_write) begin
            fresh_entries_indicator_q <= 1'b1;                          // see R5 see R15
         end else if (rd_newest || ack_ok) begin
            fresh_entries_indicator_q <= 1'b0;                          // see R15
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rd_valid_q     <= 1'b0;
         rd_hit_q       <= 1'b0;
         rd_code_q      <= 32'h0000_0000;
         rd_flags_q     <= 16'h0000;
         rd_text_identifier_q   <= 16'h0000;
         rd_stamp_q     <= 64'h0000_0000_0000_0000;
         rd_param_q     <= 32'h0000_0000;
         rd_confirmed_q <= 1'b0;
      end else if (clk_en) begin
         rd_valid_q     <= rd_req;
         rd_hit_q       <= rd_req && rd_in;
         rd_code_q      <= rd_in ? hist.rd_entry.code : 32'h0000_0000;
         rd_flags_q     <= rd_in ? hist.rd_entry.flags : 16'h0000;
         rd_text_identifier_q   <= rd_in ? hist.rd_entry.text_identifier : 16'h0000;
         rd_stamp_q     <= rd_in ? hist.rd_entry.stamp : 64'h0000_0000_0000_0000;
         rd_param_q     <= rd_in ? hist.rd_entry.param : 32'h0000_0000;
         rd_confirmed_q <= rd_in && hist.rd_confirmed;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ack_done_q    <= 1'b0;
         ack_refused_q <= 1'b0;
      end else if (clk_en) begin
         ack_done_q    <= ack_ok;                                       // see R6
         ack_refused_q <= ack_req && !ack_ok;
      end
   end

   // Only the reference clock offers its time to the master
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dc_receive_time_q <= 64'h0000_0000_0000_0000;
      end else if (clk_en && time_latch && dc_is_reference) begin
         dc_receive_time_q <= dc_sys_time;                              // see R13
      end
   end
endmodule

`default_nettype wire

// [tb/dml_log_sva.sv]
/*
 Port checker of the diagnostic message log.
 Assumes one clock domain and the port set of dml_log_top.
*/
`timescale 1ns/1ps
`default_nettype none

module dml_log_sva #(
   parameter int DEPTH = 250
) (
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic        clk_en,
   input wire logic        esm_change,
   input wire logic        time_latch,
   input wire logic        dc_is_reference,
   input wire logic [63:0] dc_sys_time,
   input wire logic        rd_req,
   input wire logic        ack_req,
   input wire logic [7:0]  ack_subindex,
   input wire logic        rd_valid_q,
   input wire logic        rd_hit_q,
   input wire logic        ack_done_q,
   input wire logic        ack_refused_q,
   input wire logic [7:0]  newest_sub_q,
   input wire logic        fresh_entries_indicator_q,
   input wire logic [7:0]  entry_count_q,
   input wire logic [63:0] dc_receive_time_q
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   rd_answer_a: assert property (rd_req && clk_en |=> rd_valid_q)
      else $error("read not answered");
   rd_single_a: assert property (clk_en && !rd_req |=> !rd_valid_q)
      else $error("read answer without request");
   ack_answer_a: assert property (ack_req && clk_en |=> ack_done_q ^ ack_refused_q)
      else $error("ack answer missing or double");
   ack_wrong_a: assert property (ack_req && clk_en && ack_subindex != newest_sub_q
      |=> ack_refused_q)
      else $error("ack of non-newest entry accepted");
   count_cap_a: assert property (entry_count_q <= DEPTH)
      else $error("entry count above depth");
   state_log_a: assert property (esm_change && clk_en ##1 clk_en
      |=> newest_sub_q != $past(newest_sub_q) && fresh_entries_indicator_q)
      else $error("state change not logged");
   newest_range_a: assert property (entry_count_q != 8'h00 |-> newest_sub_q >= 8'h06)
      else $error("newest subindex out of range");
   count_step_a: assert property (1'b1 |=> entry_count_q == $past(entry_count_q)
      || entry_count_q == $past(entry_count_q) + 8'h01)
      else $error("entry count jumped");
   time_latch_a: assert property (time_latch && dc_is_reference && clk_en
      |=> dc_receive_time_q == $past(dc_sys_time))
      else $error("receive time not latched");
   time_hold_a: assert property (clk_en && !(time_latch && dc_is_reference)
      |=> $stable(dc_receive_time_q))
      else $error("receive time changed without latch");

   cover property (rd_valid_q && rd_hit_q);
   cover property (ack_done_q);
   cover property (entry_count_q == 8'(DEPTH));
endmodule

bind dml_log_top dml_log_sva #(.DEPTH(DEPTH)) i_dml_log_sva (.ref_clk, .reset, .clk_en,
   .esm_change, .time_latch, .dc_is_reference, .dc_sys_time, .rd_req, .ack_req,
   .ack_subindex, .rd_valid_q, .rd_hit_q, .ack_done_q, .ack_refused_q, .newest_sub_q,
   .fresh_entries_indicator_q, .entry_count_q, .dc_receive_time_q);

`default_nettype wire

// [tb/dml_master_model.sv]
/*
 Bus master reading and acknowledging history entries.
 Assumes tasks are called just after a falling edge of ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module dml_master_model (
   input wire logic  ref_clk,
   input wire logic  rd_valid_q,
   input wire logic  ack_done_q,
   input wire logic  ack_refused_q,
   output logic       rd_req,
   output logic [7:0] rd_subindex,
   output logic       ack_req,
   output logic [7:0] ack_subindex
);
   initial begin
      rd_req = 1'b0;
      ack_req = 1'b0;
      rd_subindex = 8'h00;
      ack_subindex = 8'h00;
   end

   // Leading edge keeps a release and the next request in separate steps
   task automatic read(input logic [7:0] sub, output bit ok);
      @(negedge ref_clk);
      rd_req = 1'b1;
      rd_subindex = sub;
      @(negedge ref_clk);
      rd_req = 1'b0;
      rd_subindex = ~sub; // Released lines show no stale value
      for (int i = 0; i < 4 && rd_valid_q !== 1'b1; i++) @(negedge ref_clk);
      ok = (rd_valid_q === 1'b1);
   endtask

   // Normally acks the newest only; a wrong index is the caller's choice
   task automatic ack(input logic [7:0] sub, output logic [1:0] res);
      @(negedge ref_clk);
      ack_req = 1'b1;
      ack_subindex = sub;
      @(negedge ref_clk);
      ack_req = 1'b0;
      ack_subindex = ~sub;
      for (int i = 0; i < 4 && !(ack_done_q | ack_refused_q); i++) @(negedge ref_clk);
      res = {ack_done_q, ack_refused_q};
   endtask
endmodule

`default_nettype wire

// [tb/dml_log_tb_top.sv]
/*
 Self-checking bench of the diagnostic message log.
 Assumes the master model drives reads and acks; inputs change on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module dml_log_tb_top;
   logic ref_clk = 0, reset = 1, clk_en = 1;
   logic evt_valid = 0, esm_change = 0, mode_done = 0, time_latch = 0;
   logic dc_available = 0, dc_is_reference = 0;
   logic [3:0] evt_type = 0, evt_place = 0, esm_from = 0, esm_to = 0;
   logic [7:0] evt_number = 0, mode_value = 0, rd_subindex, ack_subindex;
   logic [31:0] evt_param = 0;
   logic [15:0] mode_param = 0;
   logic [63:0] dc_sys_time = 0, t, lt;
   logic rd_req, ack_req, rd_valid_q, rd_hit_q, rd_confirmed_q, ack_done_q, ack_refused_q;
   logic [31:0] rd_code_q, rd_param_q;
   logic [15:0] rd_flags_q, rd_text_identifier_q;
   logic [63:0] rd_stamp_q, dc_receive_time_q;
   logic [7:0] newest_sub_q, entry_count_q, s;
   logic fresh_entries_indicator_q;
   int nw, compares, miscompares;
   logic [15:0] etid [256];
   logic [31:0] epar [256];
   logic [63:0] est [256];
   bit edc [256], ec [256];
   logic [3:0] types [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
   logic [7:0] esm_pairs [6] = '{8'h12, 8'h21, 8'h24, 8'h42, 8'h48, 8'h84};

   always #20 ref_clk = ~ref_clk;
   // Local time as the rules define it: steps only in enabled cycles
   always @(posedge ref_clk) lt <= reset ? 64'h0 : clk_en ? lt + 64'h28 : lt;

   dml_log_top i_dml_log_top (.ref_clk, .reset, .clk_en, .evt_valid, .evt_type,
      .evt_place, .evt_number, .evt_param, .esm_change, .esm_from, .esm_to, .mode_done,
      .mode_value, .mode_param, .dc_available, .dc_is_reference, .dc_sys_time,
      .time_latch, .rd_req, .rd_subindex, .ack_req, .ack_subindex, .rd_valid_q,
      .rd_hit_q, .rd_code_q, .rd_flags_q, .rd_text_identifier_q, .rd_stamp_q, .rd_param_q,
      .rd_confirmed_q, .ack_done_q, .ack_refused_q, .newest_sub_q,
      .fresh_entries_indicator_q, .entry_count_q, .dc_receive_time_q);

   dml_master_model i_dml_master_model (.ref_clk, .rd_valid_q, .ack_done_q,
      .ack_refused_q, .rd_req, .rd_subindex, .ack_req, .ack_subindex);

   function automatic logic [7:0] sub_of(input int n);
      return 8'(6 + (n - 1) % 250);
   endfunction

   function automatic logic [15:0] sev_of(input logic [3:0] ty);
      return ty == 4'h8 ? 16'h0002 : ty == 4'h4 ? 16'h0001 : 16'h0000;
   endfunction

   task automatic final_report;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic rd(input logic [7:0] sub);
      bit ok;
      i_dml_master_model.read(sub, ok);
      if (!ok) begin
         miscompares++;
         $display("BAD %0t read not answered", $time);
         final_report;
      end
   endtask

   task automatic ak(input logic [7:0] sub, input logic [1:0] exp, input string msg);
      logic [1:0] r;
      i_dml_master_model.ack(sub, r);
      if (r == 2'b00) begin
         miscompares++;
         $display("BAD %0t ack not answered", $time);
         final_report;
      end
      chk(r, exp, msg);
   endtask

   task automatic post(input logic [1:0] kind, input logic [15:0] tid, input logic [31:0] par);
      logic [63:0] lt0;
      lt0 = lt;
      dc_available = 1'($urandom);
      dc_sys_time = {$urandom, $urandom};
      esm_change = (kind == 2'h0);
      mode_done = (kind == 2'h1);
      evt_valid = (kind == 2'h2);
      @(negedge ref_clk);
      {esm_change, mode_done, evt_valid} = 3'h0;
      repeat (3) @(negedge ref_clk);
      nw++;
      s = sub_of(nw);
      etid[s] = tid;
      epar[s] = par;
      est[s] = dc_available ? dc_sys_time : lt0;
      edc[s] = dc_available;
      ec[s] = 0;
      chk(newest_sub_q, s, "newest");
      chk(entry_count_q, nw > 250 ? 250 : nw, "count");
      chk(fresh_entries_indicator_q, 1, "fresh set");
   endtask

   task automatic verify(input logic [7:0] e);
      rd(e);
      chk(rd_hit_q, 1, "hit");
      chk(rd_text_identifier_q, etid[e], "text_identifier");
      chk(rd_code_q, {16'he000, etid[e]}, "code");
      chk(rd_flags_q, sev_of(etid[e][15:12]), "flags");
      chk(rd_param_q, epar[e], "param");
      chk(rd_confirmed_q, ec[e], "confirmed");
      if (edc[e])
         chk(rd_stamp_q, est[e], "dc stamp");
      else
         chk(rd_stamp_q, est[e], "local stamp");
   endtask

   task automatic rand_evt;
      evt_type = types[$urandom_range(4)];
      evt_place = 4'($urandom_range(7));
      evt_number = 8'($urandom);
      evt_param = $urandom;
      post(2'h2, {evt_type, evt_place, evt_number}, evt_param);
   endtask

   initial begin
      void'($urandom(12));
      repeat (3) @(negedge ref_clk);
      reset = 0;
      chk({newest_sub_q, entry_count_q}, 0, "reset state");
      rd(8'h06);
      chk({rd_hit_q, rd_code_q}, 0, "empty read");
      $display("test reset done");
      foreach (esm_pairs[i]) begin
         {esm_from, esm_to} = esm_pairs[i];
         post(2'h0, {8'h10, esm_pairs[i]}, 0);
         verify(sub_of(nw));
      end
      chk(fresh_entries_indicator_q, 0, "fresh cleared by read");
      $display("test state changes done");
      mode_value = 8'($urandom);
      mode_param = 16'($urandom);
      post(2'h1, 16'h1100, {8'h00, mode_value, mode_param});
      verify(sub_of(nw));
      repeat (12) begin
         rand_evt;
         verify(sub_of(nw));
      end
      $display("test events done");
      rand_evt;
      s = sub_of(nw);
      ak(s - 8'h01, 2'b01, "ack older refused");
      ak(s, 2'b10, "ack newest");
      ec[s] = 1;
      chk(fresh_entries_indicator_q, 0, "fresh cleared by ack");
      verify(s);
      ak(s, 2'b01, "ack twice refused");
      rand_evt;
      verify(sub_of(nw));
      rd(8'h05);
      chk({rd_hit_q, rd_code_q}, 0, "low subindex miss");
      rd(sub_of(nw) + 8'h01);
      chk(rd_hit_q, 0, "unwritten subindex miss");
      $display("test ack and miss done");
      dc_is_reference = 1;
      t = {$urandom, $urandom};
      dc_sys_time = t;
      time_latch = 1;
      @(negedge ref_clk);
      time_latch = 0;
      @(negedge ref_clk);
      chk(dc_receive_time_q, t, "latched time");
      dc_is_reference = 0;
      dc_sys_time = ~t;
      time_latch = 1;
      @(negedge ref_clk);
      time_latch = 0;
      @(negedge ref_clk);
      chk(dc_receive_time_q, t, "no latch off reference");
      clk_en = 0;
      evt_valid = 1;
      @(negedge ref_clk);
      evt_valid = 0;
      repeat (2) @(negedge ref_clk);
      chk({newest_sub_q, entry_count_q}, {sub_of(nw), 8'(nw)}, "frozen");
      clk_en = 1;
      $display("test time and freeze done");
      while (nw < 251) rand_evt;
      verify(8'h06);
      verify(8'h07);
      $display("test wrap done");
      final_report;
   end
endmodule

`default_nettype wire
